// ---- common/cgs_consts.vh ----
// constants for the clock synthesizer serial slave and its control register bank
// Function
// - Accept byte write, byte read, block write and block read transactions.
// - Block transfers walk bytes upward from byte 0, MSB first; host may stop anytime.
// - Answer only slave address 1101001 (D2 write form); low bit is direction.
// - Command bit 7: 0 block, 1 byte; bits 6:0 are the byte offset.
// - Block write: address, command, count, data bytes, each acknowledged, then stop.
// - Block read: command, repeated start, read address, count then data bytes sent.
// - Byte write: address, command with offset, one data byte acknowledged, stop.
// - Byte read: command, repeated start, read address, one byte returned, host nacks.
// - Byte 0 bit 3 unlocks writes to frequency bits 6:4,1; else they show straps.
// - Byte 0 bit 0 reports cpu mode strap; frequency bits reset to latched straps.
// - Byte 1: bit 7 spread shape, bit 6 spread enable, bits 5:4 spread amount.
// - Output enable 1 keeps a clock running; 0 stops it low at once.
// - Byte 1 bit 1 ignored in open drain mode; sets powered-down cpu pair drive.
// - Byte 1 bit 0 reads the latched current multiplier strap; writes ignored.
// - Byte 2 bit 7 raises bus clock drive strength by 20 percent.
// - Byte 3 bit 7 chooses sio clock 24 MHz (0) or 48 MHz (1).
// - Byte 3 bits 4:3 select graphics clock skew shift.
// - Byte 4 bits 5:4 select cpu to graphics frequency ratio.
// - Byte 4 bits 7,6,1,0: 1 single strength, 0 double; ref_out_b open drain only.
// - Byte 5 bit 7 selects memory buffer input threshold 1.15V or 1.05V.
// - All registers take defaults at reset; serial access is optional.
// - cpu mode strap latched at reset: 1 current mode, 0 open drain mode.
// - Device is in power-down while power_down_n is low.
`ifndef CGS_CONSTS_VH
`define CGS_CONSTS_VH
`define CGS_SLAVE_ADDR      7'h69
`define CGS_NUM_BYTES       8'h06
`define CGS_CMD_BYTE_BIT    7
`define CGS_OFS_FREQ        7'h00
`define CGS_OFS_SPREAD      7'h01
`define CGS_OFS_BUSCLK      7'h02
`define CGS_OFS_GFX         7'h03
`define CGS_OFS_PERIPH      7'h04
`define CGS_OFS_MEM         7'h05
`define CGS_FREQ_UNLOCK_BIT 3
`define CGS_RST_B0_SW       8'h00
`define CGS_RST_B1          8'h7d
`define CGS_RST_B2          8'h7f
`define CGS_RST_B3          8'h67
`define CGS_RST_B4          8'hcf
`define CGS_RST_B5          8'h7f
`endif

// ---- rtl/cgs_smbus_regs.v ----
// serial slave and control register bank of the clock synthesizer
`timescale 1ns/10ps
`include "cgs_consts.vh"
module cgs_smbus_regs
(
    input  wire       mclk_i,
    input  wire       rst_n_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output wire       sda_o,
    output wire       sda_oe_n_o,
    input  wire [3:0] freq_sel_strap_i,
    input  wire       cpu_mode_strap_i,
    input  wire       current_mult_strap_i,
    input  wire       power_down_n_i,
    output wire [3:0] freq_sel_o,
    output wire       current_mode_cpu_o,
    output wire       spread_shape_o,
    output wire       spread_enable_o,
    output wire [1:0] spread_amount_o,
    output wire       chipset_cpu_clk_en_o,
    output wire       cpu_pair_en_o,
    output wire       cpu_pair_tristate_o,
    output wire       cpu_pair_2x_drive_o,
    output wire       power_down_o,
    output wire       bus_clk_boost_o,
    output wire [5:0] bus_clk_en_o,
    output wire       sio_clk_48m_o,
    output wire       usb_clk_en_o,
    output wire       sio_clk_en_o,
    output wire [1:0] graphics_skew_sel_o,
    output wire [1:0] graphics_clk_en_o,
    output wire       usb_clk_single_o,
    output wire       sio_clk_single_o,
    output wire [1:0] graphics_ratio_sel_o,
    output wire       ref_out_a_en_o,
    output wire       ref_out_b_en_o,
    output wire       ref_out_a_single_o,
    output wire       ref_out_b_single_o,
    output wire       mem_thresh_low_o,
    output wire       feedback_out_en_o,
    output wire [5:0] mem_clk_pair_en_o
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_RX    = 3'h1;
    localparam [2:0] ST_ACK   = 3'h2;
    localparam [2:0] ST_TX    = 3'h3;
    localparam [2:0] ST_MACK  = 3'h4;
    localparam [2:0] ST_WAIT  = 3'h5;
    localparam [1:0] PH_ADDR  = 2'h0;
    localparam [1:0] PH_CMD   = 2'h1;
    localparam [1:0] PH_COUNT = 2'h2;
    localparam [1:0] PH_DATA  = 2'h3;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg  [1:0] scl_sync_q;
    reg  [1:0] sda_sync_q;
    reg        scl_prev_q;
    reg        sda_prev_q;
    reg  [1:0] pd_sync_q;
    reg  [3:0] fs_strap_q;
    reg        mode_strap_q;
    reg        mult_strap_q;

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            pd_sync_q  <= 2'h3;
            // straps caught every edge while reset is held
            fs_strap_q   <= freq_sel_strap_i;
            mode_strap_q <= cpu_mode_strap_i;
            mult_strap_q <= current_mult_strap_i;
        end
        else
        begin
            pd_sync_q  <= {pd_sync_q[0], power_down_n_i};
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    wire scl_s   = scl_sync_q[1];
    wire sda_s   = sda_sync_q[1];
    wire pd_n_s  = pd_sync_q[1];
    wire scl_ris = scl_s & ~scl_prev_q;
    wire scl_fal = ~scl_s & scl_prev_q;
    wire start_c = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire stop_c  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ------------------------------------------------------------
    // registers and straps
    // ------------------------------------------------------------
    reg  [7:0] b0_q;
    reg  [7:0] b1_q;
    reg  [7:0] b2_q;
    reg  [7:0] b3_q;
    reg  [7:0] b4_q;
    reg  [7:0] b5_q;

    // frequency bits show straps until unlocked
    wire       unlock = b0_q[`CGS_FREQ_UNLOCK_BIT];
    wire [3:0] fs_eff = unlock ? {b0_q[1], b0_q[6:4]} : fs_strap_q;

    // read view with strap bits merged
    wire [7:0] rd0 = {1'b0, fs_eff[2:0], unlock, 1'b0, fs_eff[3], mode_strap_q};
    wire [7:0] rd1 = {b1_q[7:1], mult_strap_q};

    // ------------------------------------------------------------
    // protocol engine
    // ------------------------------------------------------------
    reg  [2:0] st_q;
    reg  [1:0] ph_q;
    reg  [2:0] bit_q;
    reg  [7:0] sh_q;
    reg        rw_q;
    reg        blk_q;
    reg  [6:0] ptr_q;
    reg        cnt_sent_q;
    reg        sda_drv_q;
    reg        nack_q;

    function [7:0] rd_byte;
        input [6:0] idx;
        begin
            case (idx)
                `CGS_OFS_FREQ:   rd_byte = rd0;
                `CGS_OFS_SPREAD: rd_byte = rd1;
                `CGS_OFS_BUSCLK: rd_byte = b2_q;
                `CGS_OFS_GFX:    rd_byte = b3_q;
                `CGS_OFS_PERIPH: rd_byte = b4_q;
                `CGS_OFS_MEM:    rd_byte = b5_q;
                default:         rd_byte = 8'h00;
            endcase
        end
    endfunction

    wire [7:0] rx_byte = {sh_q[6:0], sda_s};
    wire       wr_now  = (st_q == ST_RX) && scl_ris && (bit_q == 3'h7) && (ph_q == PH_DATA);
    wire [7:0] rd_cur  = rd_byte(ptr_q);
    wire       send_cnt = blk_q & ~cnt_sent_q;
    wire [7:0] tx_next = send_cnt ? `CGS_NUM_BYTES : rd_cur;

    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            st_q       <= ST_IDLE;
            ph_q       <= PH_ADDR;
            bit_q      <= 3'h0;
            sh_q       <= 8'h00;
            rw_q       <= 1'b0;
            blk_q      <= 1'b0;
            ptr_q      <= 7'h00;
            cnt_sent_q <= 1'b0;
            sda_drv_q  <= 1'b0;
            nack_q     <= 1'b0;
        end
        else if (start_c)
        begin
            // a repeated start keeps the command pointer for the read phase
            st_q      <= ST_RX;
            ph_q      <= PH_ADDR;
            bit_q     <= 3'h0;
            sda_drv_q <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q      <= ST_IDLE;
            sda_drv_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_RX:
                    if (scl_ris)
                    begin
                        sh_q  <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7)
                        begin
                            nack_q <= 1'b0;
                            case (ph_q)
                                PH_ADDR:
                                    if (rx_byte[7:1] == `CGS_SLAVE_ADDR)
                                    begin
                                        rw_q <= rx_byte[0];
                                        st_q <= ST_ACK;
                                    end
                                    else
                                        st_q <= ST_WAIT;
                                PH_CMD:
                                begin
                                    blk_q      <= ~rx_byte[`CGS_CMD_BYTE_BIT];
                                    ptr_q      <= rx_byte[`CGS_CMD_BYTE_BIT] ? rx_byte[6:0] : 7'h00;
                                    cnt_sent_q <= 1'b0;
                                    st_q       <= ST_ACK;
                                end
                                PH_COUNT: st_q <= ST_ACK;
                                default:
                                begin
                                    ptr_q <= ptr_q + 7'h01;
                                    st_q  <= ST_ACK;
                                end
                            endcase
                        end
                    end
                ST_ACK:
                    if (scl_fal)
                    begin
                        if (!sda_drv_q)
                            sda_drv_q <= 1'b1;
                        else if (ph_q == PH_ADDR && rw_q)
                        begin
                            // first bit goes out in this low phase
                            sda_drv_q  <= ~tx_next[7];
                            st_q       <= ST_TX;
                            bit_q      <= 3'h0;
                            sh_q       <= tx_next;
                            cnt_sent_q <= 1'b1;
                            ptr_q      <= send_cnt ? ptr_q : ptr_q + 7'h01;
                        end
                        else
                        begin
                            sda_drv_q <= 1'b0;
                            st_q      <= ST_RX;
                            bit_q     <= 3'h0;
                            if (ph_q == PH_ADDR)
                                ph_q <= PH_CMD;
                            else if (ph_q == PH_CMD)
                                ph_q <= blk_q ? PH_COUNT : PH_DATA;
                            else
                                ph_q <= PH_DATA;
                        end
                    end
                ST_TX:
                    if (scl_fal)
                    begin
                        // after the eighth bit the line is freed for the host's answer
                        sh_q      <= {sh_q[6:0], 1'b0};
                        bit_q     <= bit_q + 3'h1;
                        sda_drv_q <= (bit_q == 3'h7) ? 1'b0 : ~sh_q[6];
                        if (bit_q == 3'h7)
                            st_q <= ST_MACK;
                    end
                ST_MACK:
                    if (scl_ris)
                        nack_q <= sda_s;
                    else if (scl_fal)
                    begin
                        if (nack_q)
                            st_q <= ST_WAIT;
                        else
                        begin
                            st_q      <= ST_TX;
                            bit_q     <= 3'h0;
                            sh_q      <= tx_next;
                            ptr_q     <= ptr_q + 7'h01;
                            sda_drv_q <= ~tx_next[7];
                        end
                    end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            // software copy of frequency bits starts at strap values
            b0_q <= `CGS_RST_B0_SW | {1'b0, fs_strap_q[2:0], 2'h0, fs_strap_q[3], 1'b0};
            b1_q <= `CGS_RST_B1;
            b2_q <= `CGS_RST_B2;
            b3_q <= `CGS_RST_B3;
            b4_q <= `CGS_RST_B4;
            b5_q <= `CGS_RST_B5;
        end
        else if (wr_now)
        begin
            case (ptr_q)
                // frequency bits only when the written byte sets bit 3; bit 0 strap only
                `CGS_OFS_FREQ:
                    b0_q <= {1'b0, (rx_byte[3] ? rx_byte[6:4] : b0_q[6:4]),
                             rx_byte[3], 1'b0, (rx_byte[3] ? rx_byte[1] : b0_q[1]), 1'b0};
                `CGS_OFS_SPREAD: b1_q <= {rx_byte[7:1], 1'b0};
                `CGS_OFS_BUSCLK: b2_q <= rx_byte;
                `CGS_OFS_GFX:    b3_q <= rx_byte;
                `CGS_OFS_PERIPH: b4_q <= rx_byte;
                `CGS_OFS_MEM:    b5_q <= rx_byte;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open drain data: enable low while pulling the line low
    assign sda_o       = 1'b0;
    assign sda_oe_n_o  = ~sda_drv_q;

    assign freq_sel_o          = fs_eff;
    assign current_mode_cpu_o  = mode_strap_q;
    assign spread_shape_o      = b1_q[7];
    assign spread_enable_o     = b1_q[6];
    assign spread_amount_o     = b1_q[5:4];
    assign chipset_cpu_clk_en_o = b1_q[3];
    assign cpu_pair_en_o       = b1_q[2];
    assign power_down_o        = ~pd_n_s;
    // powered-down cpu pair drive, current mode only
    assign cpu_pair_tristate_o = mode_strap_q & ~pd_n_s & b1_q[1];
    assign cpu_pair_2x_drive_o = mode_strap_q & ~pd_n_s & ~b1_q[1];
    assign bus_clk_boost_o     = b2_q[7];
    assign bus_clk_en_o        = {b2_q[6], b2_q[4:0]};
    assign sio_clk_48m_o       = b3_q[7];
    assign usb_clk_en_o        = b3_q[6];
    assign sio_clk_en_o        = b3_q[5];
    assign graphics_skew_sel_o = b3_q[4:3];
    assign graphics_clk_en_o   = b3_q[1:0];
    // strengths; ref_out_b only in open drain mode
    assign usb_clk_single_o    = b4_q[7];
    assign sio_clk_single_o    = b4_q[6];
    assign graphics_ratio_sel_o = b4_q[5:4];
    assign ref_out_a_en_o      = b4_q[3];
    assign ref_out_b_en_o      = b4_q[2] & ~mode_strap_q;
    assign ref_out_a_single_o  = b4_q[1];
    assign ref_out_b_single_o  = b4_q[0];
    assign mem_thresh_low_o    = b5_q[7];
    assign feedback_out_en_o   = b5_q[6];
    assign mem_clk_pair_en_o   = b5_q[5:0];

endmodule

// ---- verification/cgs_smbus_checker.sv ----
// assertion checker for the serial slave and control register bank
`timescale 1ns/10ps
module cgs_smbus_checker
(
    input logic mclk_i,
    input logic rst_n_i,
    input logic scl_i,
    input logic sda_o,
    input logic sda_oe_n_o,
    input logic power_down_n_i,
    input logic power_down_o,
    input logic current_mode_cpu_o,
    input logic cpu_pair_tristate_o,
    input logic cpu_pair_2x_drive_o,
    input logic ref_out_b_en_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------
    // bus phases
    // ----------------------------------------
    sequence s_scl_idle;
        scl_i [*8];
    endsequence
    sequence s_scl_held;
        scl_i [*3];
    endsequence

    AST_IDLE_RELEASED: assert property (s_scl_idle |-> sda_oe_n_o)
        else $error("data line held while bus idle");
    // a data change under a high clock would read as start or stop
    AST_SDA_STEADY: assert property (s_scl_held |-> $stable(sda_oe_n_o))
        else $error("data line moved while clock high");
    // pulling the line while the clock is high would read as a start
    AST_SDA_ZERO: assert property ($fell(sda_oe_n_o) |-> !scl_i && sda_o == 1'b0)
        else $error("data line pulled while clock high");
    AST_MODE_LATCHED: assert property ($past(rst_n_i) |-> $stable(current_mode_cpu_o))
        else $error("cpu mode changed outside reset");
    // the pin passes two flops before it reaches the flag
    AST_PD_FLAG: assert property (power_down_o == !$past(power_down_n_i, 2))
        else $error("power-down flag wrong");
    AST_PAIR_TRI: assert property (cpu_pair_tristate_o |-> current_mode_cpu_o && power_down_o)
        else $error("tristate outside current mode power-down");
    AST_PAIR_2X: assert property (cpu_pair_2x_drive_o |-> current_mode_cpu_o && power_down_o)
        else $error("double drive outside current mode power-down");
    AST_PAIR_ONE: assert property ((current_mode_cpu_o && power_down_o) |->
        (cpu_pair_tristate_o != cpu_pair_2x_drive_o))
        else $error("powered-down pair drive not exactly one");
    AST_REFB_MODE: assert property (current_mode_cpu_o |-> !ref_out_b_en_o)
        else $error("second reference enabled in current mode");
    COV_IDLE: cover property (s_scl_idle);
endmodule

bind cgs_smbus_regs cgs_smbus_checker u_chk
(
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .power_down_n_i(power_down_n_i), .power_down_o(power_down_o),
    .current_mode_cpu_o(current_mode_cpu_o), .cpu_pair_tristate_o(cpu_pair_tristate_o),
    .cpu_pair_2x_drive_o(cpu_pair_2x_drive_o), .ref_out_b_en_o(ref_out_b_en_o)
);

// ---- verification/cgs_host_model.sv ----
// serial bus host model: drives the clock and pulls the open-drain data line
`timescale 1ns/10ps
module cgs_host_model
(
    input  wire mclk_i,
    input  wire sda_i,
    output reg  scl_o,
    output reg  sda_low_o
);
    reg [7:0] wbuf [0:7];
    reg [7:0] rbuf [0:7];
    reg       acked;
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // quarter of the 800 ns serial period; clock stands high between frames
    task qtr;
        repeat (2) @(posedge mclk_i);
    endtask
    // one bit, sampled mid high phase
    task bit_io(input reg b, output reg r);
    begin
        qtr;
        sda_low_o <= ~b;
        qtr;
        scl_o <= 1'b1;
        qtr;
        r = sda_i;
        qtr;
        scl_o <= 1'b0;
    end
    endtask
    // start or repeated start; extra wait lets the slave drop its ack first
    task start_c;
    begin
        qtr;
        qtr;
        sda_low_o <= 1'b0;
        qtr;
        scl_o <= 1'b1;
        qtr;
        sda_low_o <= 1'b1;
        qtr;
        scl_o <= 1'b0;
    end
    endtask
    task stop_c;
    begin
        qtr;
        sda_low_o <= 1'b1;
        qtr;
        scl_o <= 1'b1;
        qtr;
        sda_low_o <= 1'b0;
        qtr;
    end
    endtask
    task send(input reg [7:0] v);
        integer i;
        reg     r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        acked = acked & ~r;
    end
    endtask
    task recv(input reg last, output reg [7:0] v);
        integer i;
        reg     r;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(last, r);
    end
    endtask
    // byte write if command bit 7 set, block write with count otherwise
    task write_xfer(input reg [7:0] addr, input reg [7:0] cmd, input integer n);
        integer k;
    begin
        acked = 1'b1;
        start_c;
        send(addr);
        send(cmd);
        if (!cmd[7])
            send(n[7:0]);
        for (k = 0; k < n; k = k + 1)
            send(wbuf[k]);
        stop_c;
    end
    endtask
    // read n bytes, not-acknowledge on the last one
    task read_xfer(input reg [7:0] cmd, input integer n);
        integer k;
    begin
        acked = 1'b1;
        start_c;
        send(8'hd2);
        send(cmd);
        start_c;
        send(8'hd3);
        for (k = 0; k < n; k = k + 1)
            recv(k == n - 1, rbuf[k]);
        stop_c;
    end
    endtask
endmodule

// ---- verification/cgs_smbus_regs_tb.sv ----
// self-checking bench for the serial slave and control register bank
`timescale 1ns/10ps
`include "cgs_consts.vh"
module cgs_smbus_regs_tb;
    reg        mclk_i;
    reg        rst_n_i;
    reg        pd_n;
    reg  [3:0] fs_strap;
    reg        mode_strap;
    reg        mult_strap;
    reg [39:0] wv;
    wire       scl, host_low, sda, sda_o, sda_oe_n_o, current_mode_cpu_o, spread_shape_o;
    wire       cpu_pair_tristate_o, cpu_pair_2x_drive_o, power_down_o, sio_clk_48m_o;
    wire       ref_out_b_en_o, mem_thresh_low_o;
    wire [3:0] freq_sel_o;
    wire [5:0] bus_clk_en_o, mem_clk_pair_en_o;
    wire [1:0] graphics_skew_sel_o, graphics_ratio_sel_o;
    integer    bad_count, checks, k;

    assign sda = ~host_low & (sda_oe_n_o | sda_o);
    always #50 mclk_i = ~mclk_i;

    cgs_host_model u_cgs_host_model (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(host_low));
    cgs_smbus_regs u_cgs_smbus_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .freq_sel_strap_i(fs_strap),
        .cpu_mode_strap_i(mode_strap), .current_mult_strap_i(mult_strap),
        .power_down_n_i(pd_n), .freq_sel_o(freq_sel_o), .current_mode_cpu_o(current_mode_cpu_o),
        .spread_shape_o(spread_shape_o), .spread_enable_o(), .spread_amount_o(),
        .chipset_cpu_clk_en_o(), .cpu_pair_en_o(), .cpu_pair_tristate_o(cpu_pair_tristate_o),
        .cpu_pair_2x_drive_o(cpu_pair_2x_drive_o), .power_down_o(power_down_o),
        .bus_clk_boost_o(), .bus_clk_en_o(bus_clk_en_o), .sio_clk_48m_o(sio_clk_48m_o),
        .usb_clk_en_o(), .sio_clk_en_o(), .graphics_skew_sel_o(graphics_skew_sel_o),
        .graphics_clk_en_o(), .usb_clk_single_o(), .sio_clk_single_o(),
        .graphics_ratio_sel_o(graphics_ratio_sel_o), .ref_out_a_en_o(),
        .ref_out_b_en_o(ref_out_b_en_o), .ref_out_a_single_o(), .ref_out_b_single_o(),
        .mem_thresh_low_o(mem_thresh_low_o), .feedback_out_en_o(),
        .mem_clk_pair_en_o(mem_clk_pair_en_o));

    task chk(input reg [7:0] got, input reg [7:0] want);
    begin
        checks = checks + 1;
        if (got !== want)
        begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    end
    endtask
    task chk1(input reg got, input reg want);
        chk({7'h00, got}, {7'h00, want});
    endtask
    task wr(input reg [7:0] addr, input reg [6:0] ofs, input reg [7:0] val, input reg ack);
    begin
        u_cgs_host_model.wbuf[0] = val;
        u_cgs_host_model.write_xfer(addr, {1'b1, ofs}, 1);
        chk1(u_cgs_host_model.acked, ack);
    end
    endtask
    task rd(input reg [6:0] ofs, input reg [7:0] want);
    begin
        u_cgs_host_model.read_xfer({1'b1, ofs}, 1);
        chk1(u_cgs_host_model.acked, 1'b1);
        chk(u_cgs_host_model.rbuf[0], want);
    end
    endtask
    task do_reset;
    begin
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
    end
    endtask
    task results;
    begin
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    // a hung transfer ends the run as a mismatch
    initial
    begin
        repeat (90000) @(posedge mclk_i);
        bad_count = bad_count + 1;
        results;
    end

    initial
    begin
        mclk_i = 1'b0;
        rst_n_i = 1'b0;
        pd_n = 1'b1;
        fs_strap = 4'b1010;
        mode_strap = 1'b1;
        mult_strap = 1'b0;
        bad_count = 0;
        checks = 0;
        wv = 40'h81_209c_3080;
        do_reset;
        u_cgs_host_model.read_xfer(8'h00, 7);
        chk(u_cgs_host_model.rbuf[0], `CGS_NUM_BYTES);
        chk(u_cgs_host_model.rbuf[1], 8'h23);
        chk(u_cgs_host_model.rbuf[2], `CGS_RST_B1 & 8'hfe);
        chk(u_cgs_host_model.rbuf[3], `CGS_RST_B2);
        chk(u_cgs_host_model.rbuf[4], `CGS_RST_B3);
        chk(u_cgs_host_model.rbuf[5], `CGS_RST_B4);
        chk(u_cgs_host_model.rbuf[6], `CGS_RST_B5);
        chk({4'h0, freq_sel_o}, {4'h0, fs_strap});
        $display("test defaults done");
        for (k = 0; k < 5; k = k + 1)
        begin
            wr(8'hd2, k + 1, wv[39 - 8 * k -: 8], 1'b1);
            rd(k + 1, wv[39 - 8 * k -: 8] & ((k == 0) ? 8'hfe : 8'hff));
        end
        chk1(spread_shape_o, 1'b1);
        chk({2'b00, bus_clk_en_o}, 8'h00);
        chk1(sio_clk_48m_o, 1'b1);
        chk1(mem_thresh_low_o, 1'b1);
        chk({2'b00, mem_clk_pair_en_o}, 8'h00);
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(8'hd2, 7'h03, {3'b001, k[1:0], 3'b100}, 1'b1);
            wr(8'hd2, 7'h04, {2'b11, k[1:0], 4'hf}, 1'b1);
            chk({6'h00, graphics_skew_sel_o}, k[7:0]);
            chk({6'h00, graphics_ratio_sel_o}, k[7:0]);
        end
        $display("test byte access done");
        wr(8'hd2, 7'h00, 8'h72, 1'b1);
        rd(7'h00, 8'h23);
        wr(8'hd2, 7'h00, 8'h5a, 1'b1);
        rd(7'h00, 8'h5b);
        chk({4'h0, freq_sel_o}, 8'h0d);
        wr(8'hd4, 7'h05, 8'h00, 1'b0);
        rd(7'h05, 8'h80);
        wr(8'hd2, 7'h07, 8'h55, 1'b1);
        rd(7'h06, 8'h00);
        $display("test unlock and refusal done");
        u_cgs_host_model.wbuf[0] = 8'h08;
        u_cgs_host_model.wbuf[1] = 8'h40;
        u_cgs_host_model.wbuf[2] = 8'hff;
        u_cgs_host_model.write_xfer(8'hd2, 8'h00, 3);
        chk1(u_cgs_host_model.acked, 1'b1);
        u_cgs_host_model.read_xfer(8'h00, 3);
        chk(u_cgs_host_model.rbuf[1], 8'h09);
        chk(u_cgs_host_model.rbuf[2], 8'h40);
        rd(7'h02, 8'hff);
        $display("test block transfers done");
        pd_n <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk1(power_down_o, 1'b1);
        chk1(cpu_pair_2x_drive_o, 1'b1);
        wr(8'hd2, 7'h01, 8'h42, 1'b1);
        chk1(cpu_pair_tristate_o, 1'b1);
        pd_n <= 1'b1;
        mode_strap <= 1'b0;
        mult_strap <= 1'b1;
        fs_strap <= 4'b0101;
        do_reset;
        chk1(current_mode_cpu_o, 1'b0);
        chk1(ref_out_b_en_o, 1'b1);
        rd(7'h00, 8'h50);
        rd(7'h01, `CGS_RST_B1);
        pd_n <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk1(cpu_pair_tristate_o | cpu_pair_2x_drive_o, 1'b0);
        $display("test power-down and mode done");
        results;
    end
endmodule
